/* File: dcs_drive_objects.sv */
// drive control and status objects with command decoder
`timescale 1ns/1ps
`default_nettype none
module dcs_drive_objects (
    input  wire logic        clock,
    input  wire logic        rst_n,
    // object access port from the fieldbus side
    input  wire logic [15:0] obj_index,
    input  wire logic        obj_wr,
    input  wire logic        obj_rd,
    input  wire logic [31:0] obj_wdata,
    output logic      [31:0] obj_rdata,
    output logic             obj_ack,
    output logic             obj_err,
    // safety pins, asynchronous
    input  wire logic [3:0]  safety_req_in,
    input  wire logic [1:0]  edm_out_in,
    // safety state from on-chip logic
    input  wire logic        safety_monitoring,
    input  wire logic        safety_safe_state,
    input  wire logic        hard_wired_power_cutoff_flag,
    input  wire logic        active_mode_operating,
    // error capture from alarm logic
    input  wire logic        err_load,
    input  wire logic [15:0] err_code_in,
    // decoded drive commands
    output logic [15:0]      command_word,
    output logic             cmd_shutdown,
    output logic             cmd_switch_on,
    output logic             cmd_enable_op,
    output logic             cmd_disable_voltage,
    output logic             cmd_quick_stop,
    output logic             fault_reset_pulse,
    output logic             halt_request,
    output logic             pos_torque_limit_en,
    output logic             neg_torque_limit_en
);

    ////////////////////////////////////////////////////////////////////////
    // block overview
    //
    // the fieldbus side reaches three objects through one index port:
    //   - the safety monitor word, a live 32-bit view, never stored
    //   - the last error code, loaded only by the alarm logic
    //   - the command word, the one object the master may write
    //
    // access timing
    //   - a request is taken on any edge with obj_wr or obj_rd high
    //   - ack, err and read data follow one edge later, for one cycle
    //   - back to back requests are fine, one per cycle
    //   - a write wins when both strobes are high in one cycle
    //
    // command timing
    //   - a write stores on the taking edge
    //   - decoded commands and the word copy move one edge later
    //   - the fault reset pulse also lands one edge after the store
    //
    // hazards and limits
    //   - safety pins are asynchronous, so they pass two flops first;
    //     right after reset the request bits read as active (all ones)
    //     until the pin levels have walked through the synchroniser
    //   - the on-chip safety state levels are used as they come, since
    //     they already live on this clock
    //   - the fault reset edge is taken on the stored word, not on the
    //     write strobe; rewriting a one gives no second pulse, so the
    //     master has to write a zero in between
    //   - the decoder only tells which command is asked for; whether
    //     0111 means switch on or disable operation depends on the
    //     drive state, which lives outside this block
    //   - mode specific bits are kept in the word but never decoded
    //   - outputs are all registered, trading one cycle of latency for
    //     clean, glitch free levels at the drive state machine
    //   - nothing here is saved across power cycles; reset clears all

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [5:0] sync1_ff;          // first stage, read only by second
    logic [5:0] sync2_ff;          // safe to use

    // two stages before any logic looks at the pins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync1_ff <= 6'h00;
            sync2_ff <= 6'h00;
        end else begin
            sync1_ff <= {edm_out_in, safety_req_in};
            sync2_ff <= sync1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // safety monitor word, live, never stored
    logic [31:0] safety_mon;       // assembled view
    always_comb begin
        safety_mon = 32'h0000_0000;
        safety_mon[dcs_pkg::MON_REQ_LSB +: 4] = ~sync2_ff[3:0];
        safety_mon[dcs_pkg::MON_EDM_A]        = sync2_ff[4];
        safety_mon[dcs_pkg::MON_EDM_B]        = sync2_ff[5];
        safety_mon[dcs_pkg::MON_MONITORING]   = safety_monitoring;
        safety_mon[dcs_pkg::MON_SAFE_STATE]   = safety_safe_state;
        safety_mon[dcs_pkg::MON_PWR_CUTOFF]   = hard_wired_power_cutoff_flag;
        safety_mon[dcs_pkg::MON_ACTIVE_MODE]  = active_mode_operating;
    end

    ////////////////////////////////////////////////////////////////////////
    // access decode
    logic [15:0] cmd_ff;           // command word store
    logic [15:0] err_ff;           // last error code
    logic [15:0] cw_prev_ff;       // previous command word, for edge
    wire  hit_mon = (obj_index == dcs_pkg::IDX_SAFETY_MON);
    wire  hit_err = (obj_index == dcs_pkg::IDX_ERROR_CODE);
    wire  hit_cmd = (obj_index == dcs_pkg::IDX_COMMAND);
    wire  hit_any = hit_mon | hit_err | hit_cmd;
    // writes land only on the command word; the others are read-only
    wire  wr_cmd  = obj_wr & hit_cmd;
    wire  bad_acc = (obj_wr & ~hit_cmd) | (obj_rd & ~obj_wr & ~hit_any);
    wire  [31:0] rd_mux = hit_mon ? safety_mon :
                          hit_err ? {16'h0000, err_ff} :
                          hit_cmd ? {16'h0000, cmd_ff} : 32'h0000_0000;
    wire  [15:0] nxt_cmd = wr_cmd ? obj_wdata[15:0] : cmd_ff;

    // access answer one cycle after the request
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            obj_rdata <= 32'h0000_0000;
            obj_ack   <= 1'b0;
            obj_err   <= 1'b0;
        end else begin
            obj_ack   <= obj_wr | obj_rd;
            obj_err   <= bad_acc;
            // a write takes priority; read data only on clean reads
            obj_rdata <= (obj_rd & ~obj_wr) ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stored objects
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cmd_ff     <= dcs_pkg::COMMAND_RST;
            cw_prev_ff <= dcs_pkg::COMMAND_RST;
            err_ff     <= dcs_pkg::ERROR_CODE_RST;
        end else begin
            cmd_ff     <= nxt_cmd;
            cw_prev_ff <= cmd_ff;
            if (err_load)
                err_ff <= err_code_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command decoder; reserved and mode bits are not looked at
    wire fr_bit = cmd_ff[dcs_pkg::CW_FAULT_RESET];
    wire so     = cmd_ff[dcs_pkg::CW_SWITCH_ON];
    wire ev     = cmd_ff[dcs_pkg::CW_EN_VOLTAGE];
    wire qs_n   = cmd_ff[dcs_pkg::CW_QUICK_STOP_N];
    wire eo     = cmd_ff[dcs_pkg::CW_EN_OPERATION];
    // state commands only count while fault reset is low
    wire d_shutdown = ~fr_bit & qs_n & ev & ~so;
    wire d_dis_volt = ~fr_bit & ~ev;
    wire d_qstop    = ~fr_bit & ~qs_n & ev;
    // 0111 is switch on or, from enabled, disable operation
    wire d_sw_on    = ~fr_bit & qs_n & ev & so;
    wire d_en_op    = d_sw_on & eo;
    // edge is on the stored word, so one write pair makes one pulse
    wire d_fault_rs = fr_bit & ~cw_prev_ff[dcs_pkg::CW_FAULT_RESET];

    // registered command outputs
    // every output is a flop so the drive logic never sees a decode
    // glitch while the stored word changes; the cost is one cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            command_word        <= dcs_pkg::COMMAND_RST;
            cmd_shutdown        <= 1'b0;
            cmd_switch_on       <= 1'b0;
            cmd_enable_op       <= 1'b0;
            cmd_disable_voltage <= 1'b0;
            cmd_quick_stop      <= 1'b0;
            fault_reset_pulse   <= 1'b0;
            halt_request        <= 1'b0;
            pos_torque_limit_en <= 1'b0;
            neg_torque_limit_en <= 1'b0;
        end else begin
            command_word        <= cmd_ff;
            cmd_shutdown        <= d_shutdown;
            cmd_switch_on       <= d_sw_on;
            cmd_enable_op       <= d_en_op;
            cmd_disable_voltage <= d_dis_volt;
            cmd_quick_stop      <= d_qstop;
            fault_reset_pulse   <= d_fault_rs;
            halt_request        <= cmd_ff[dcs_pkg::CW_HALT];
            pos_torque_limit_en <= cmd_ff[dcs_pkg::CW_POS_TLIM];
            neg_torque_limit_en <= cmd_ff[dcs_pkg::CW_NEG_TLIM];
        end
    end

endmodule : dcs_drive_objects
`default_nettype wire

/* File: dcs_drive_objects_props.sv */
// port assertions for the drive object block
`timescale 1ns/1ps
`default_nettype none
module dcs_drive_objects_props (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        obj_wr,
    input wire logic        obj_rd,
    input wire logic        obj_ack,
    input wire logic        obj_err,
    input wire logic        fault_reset_pulse,
    input wire logic        cmd_enable_op,
    input wire logic        cmd_disable_voltage,
    input wire logic        cmd_quick_stop,
    input wire logic        halt_request,
    input wire logic        pos_torque_limit_en,
    input wire logic        neg_torque_limit_en,
    input wire logic [15:0] obj_index,
    input wire logic [15:0] command_word,
    input wire logic [31:0] obj_wdata,
    input wire logic [31:0] obj_rdata
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic [15:0] cw = command_word;
    sequence cw_write; obj_wr && obj_index == 16'h6040; endsequence
    sequence mon_read; obj_rd && !obj_wr && obj_index == 16'h2720; endsequence
    ack_after_req_a: assert property ((obj_wr || obj_rd) |=> obj_ack)
        else $error("ack missing");
    ro_write_a: assert property (obj_wr && obj_index != 16'h6040 |=> obj_err)
        else $error("read-only write accepted");
    cmd_store_a: assert property (cw_write |=> ##1 cw == $past(obj_wdata[15:0], 2))
        else $error("command word not stored");
    mon_zero_a: assert property (mon_read |=> (obj_rdata & 32'hfffe_f0c0) == 0)
        else $error("reserved monitor bit set");
    fault_edge_a: assert property ($rose(cw[7]) |-> fault_reset_pulse ##1 !fault_reset_pulse)
        else $error("fault reset pulse wrong");
    fault_cause_a: assert property (fault_reset_pulse |-> $rose(cw[7]))
        else $error("fault reset without edge");
    torque_halt_a: assert property ({pos_torque_limit_en, neg_torque_limit_en, halt_request} == {cw[11], cw[12], cw[8]})
        else $error("limit or halt mismatch");
    state_cmd_a: assert property ($past(rst_n) |-> {cmd_enable_op, cmd_disable_voltage, cmd_quick_stop} ==
        {!cw[7] && cw[3:0] == 4'hf, !cw[7] && !cw[1], !cw[7] && cw[2:1] == 2'b01}) else $error("state decode");
endmodule : dcs_drive_objects_props
bind dcs_drive_objects dcs_drive_objects_props u_props (.*);
`default_nettype wire

/* File: dcs_master_model.sv */
// fieldbus master model for the object access port
`timescale 1ns/1ps
`default_nettype none
module dcs_master_model (
    input  wire logic        clock,
    input  wire logic        obj_ack,
    input  wire logic        obj_err,
    input  wire logic [31:0] obj_rdata,
    output var logic  [15:0] obj_index,
    output var logic         obj_wr,
    output var logic         obj_rd,
    output var logic  [31:0] obj_wdata
);
    initial {obj_index, obj_wr, obj_rd, obj_wdata} = '0;
    // one request per taking edge; a longer strobe would count twice
    task acc(input logic w, input logic [15:0] i, input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge clock);
        #1 {obj_wr, obj_rd, obj_index, obj_wdata} = {w, !w, i, d};
        @(posedge clock);
        #1 {obj_wr, obj_rd, obj_wdata} = {2'b00, ~d};
        q = (obj_ack === 1'b1) ? obj_rdata : 32'hdead_beef;
        e = obj_err;
    endtask : acc
endmodule : dcs_master_model
`default_nettype wire

/* File: dcs_pkg.sv */
// constants for the drive control and status object block
`default_nettype none
package dcs_pkg;
    // object indices
    localparam logic [15:0] IDX_SAFETY_MON  = 16'h2720;
    localparam logic [15:0] IDX_ERROR_CODE  = 16'h603f;
    localparam logic [15:0] IDX_COMMAND     = 16'h6040;
    // reset values
    localparam logic [15:0] ERROR_CODE_RST  = 16'h0000;
    localparam logic [15:0] COMMAND_RST     = 16'h0000;
    // safety monitor field positions
    localparam int MON_REQ_LSB      = 0;
    localparam int MON_EDM_A        = 4;
    localparam int MON_EDM_B        = 5;
    localparam int MON_MONITORING   = 8;
    localparam int MON_SAFE_STATE   = 9;
    localparam int MON_PWR_CUTOFF   = 10;
    localparam int MON_ACTIVE_MODE  = 16;
    // command word field positions
    localparam int CW_SWITCH_ON     = 0;
    localparam int CW_EN_VOLTAGE    = 1;
    localparam int CW_QUICK_STOP_N  = 2;
    localparam int CW_EN_OPERATION  = 3;
    localparam int CW_FAULT_RESET   = 7;
    localparam int CW_HALT          = 8;
    localparam int CW_POS_TLIM      = 11;
    localparam int CW_NEG_TLIM      = 12;
endpackage : dcs_pkg
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the drive object block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock, rst_n, obj_wr, obj_rd, obj_ack, obj_err, err_load, safety_monitoring, safety_safe_state, e;
    logic hard_wired_power_cutoff_flag, active_mode_operating, cmd_shutdown, cmd_switch_on, cmd_enable_op;
    logic cmd_disable_voltage, cmd_quick_stop, fault_reset_pulse, halt_request, pos_torque_limit_en;
    logic neg_torque_limit_en;
    logic [1:0] edm_out_in;
    logic [3:0] safety_req_in;
    logic [15:0] obj_index, command_word, err_code_in;
    logic [31:0] obj_wdata, obj_rdata, q;
    int fail_count = 0;
    int tests_run = 0;
    logic [15:0] w [7] = '{16'h0006, 16'h0007, 16'h000f, 16'h0000, 16'h0002, 16'h1900, 16'he48f};
    dcs_drive_objects dut (.*);
    dcs_master_model mst (.*);
    initial begin clock = 0; forever #12.5 clock = ~clock; end
    initial begin #200us fail_count++; report_and_stop; end
    task chk(input string n, input logic [31:0] x, input logic [31:0] s);
        tests_run++;
        if (s !== x) begin fail_count++; $display("ERROR %s expected %h seen %h", n, x, s); end
    endtask : chk
    // expected {shutdown, switch on, enable op, disable voltage, quick stop, halt, pos, neg}
    function automatic logic [7:0] exp(input logic [15:0] c);
        return {!c[7] & c[2:0] == 3'h6, !c[7] & c[2:0] == 3'h7, !c[7] & c[3:0] == 4'hf, !c[7] & !c[1],
                !c[7] & c[2:1] == 2'b01, c[8], c[11], c[12]};
    endfunction : exp
    task t_monitor; // two opposite pin patterns, then a refused write
        {safety_req_in, edm_out_in, safety_monitoring, safety_safe_state, hard_wired_power_cutoff_flag,
         active_mode_operating} = {4'ha, 2'h1, 4'b1011};
        repeat (3) @(posedge clock);
        mst.acc(0, 16'h2720, 0, q, e); chk("monitor", 32'h0001_0515, q);
        {safety_req_in, edm_out_in, safety_monitoring, safety_safe_state, hard_wired_power_cutoff_flag,
         active_mode_operating} = {4'h5, 2'h2, 4'b0100};
        repeat (3) @(posedge clock);
        mst.acc(0, 16'h2720, 0, q, e); chk("monitor", 32'h0000_022a, q);
        mst.acc(1, 16'h2720, '1, q, e); chk("monitor write err", 1, e);
        $display("monitor test done");
    endtask : t_monitor
    task t_error; // reset value, capture, refused write
        mst.acc(0, 16'h603f, 0, q, e); chk("error code", 0, q);
        mst.acc(0, 16'h1234, 0, q, e); chk("unmapped", 1, {q[30:0], e});
        #1 {err_load, err_code_in} = {1'b1, 16'h0a5c};
        @(posedge clock);
        #1 err_load = 0;
        mst.acc(1, 16'h603f, 1, q, e); chk("error write err", 1, e);
        mst.acc(0, 16'h603f, 0, q, e); chk("error code", 32'h0a5c, q);
        $display("error test done");
    endtask : t_error
    task t_cmd; // every command code, limits, halt, reserved bits
        mst.acc(0, 16'h6040, 0, q, e); chk("command reset", 0, q);
        foreach (w[i]) begin
            mst.acc(1, 16'h6040, {16'hffff, w[i]}, q, e);
            // decoded outputs follow the stored word one edge later
            @(posedge clock);
            #1 chk("command word", w[i], command_word);
            chk("decode", exp(w[i]), {cmd_shutdown, cmd_switch_on, cmd_enable_op, cmd_disable_voltage, cmd_quick_stop,
                halt_request, pos_torque_limit_en, neg_torque_limit_en});
            mst.acc(0, 16'h6040, 0, q, e); chk("readback", w[i], q);
        end
        $display("command test done");
    endtask : t_cmd
    task t_fault; // pulse only on a written 0 then 1
        mst.acc(1, 16'h6040, 32'h80, q, e);
        @(posedge clock);
        #1 chk("no pulse", 0, fault_reset_pulse);
        mst.acc(1, 16'h6040, 0, q, e);
        mst.acc(1, 16'h6040, 32'h80, q, e);
        @(posedge clock);
        #1 chk("pulse", 1, fault_reset_pulse);
        @(posedge clock);
        #1 chk("pulse width", 0, fault_reset_pulse);
        $display("fault test done");
    endtask : t_fault
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    initial begin
        {rst_n, err_load, err_code_in, safety_req_in, edm_out_in, safety_monitoring, safety_safe_state} = '0;
        {hard_wired_power_cutoff_flag, active_mode_operating} = '0;
        repeat (16) @(posedge clock);
        #1 rst_n = 1;
        t_error;
        t_monitor;
        t_cmd;
        t_fault;
        report_and_stop;
    end
endmodule : testbench
`default_nettype wire
